// ===== src/lmg_display_ctrl.sv
// display controller: serial register port, blink timing, glyph scan
`timescale 1ns/10ps
module lmg_display_ctrl
  import lmg_pkg::*;
#(
  parameter int BLINK_HALF_CYC = BLINK_SLOW_HALF_CYC,
  parameter int SCAN_COL_CYC   = COL_CYC
) (
  input  wire logic       clk_sys_in,
  input  wire logic       nrst_in,
  input  wire logic       sclk_in,
  input  wire logic       cs_n_in,
  input  wire logic       din_in,
  output logic            dout_out,
  input  wire logic [6:0] rom_col_in,
  output logic      [9:0] rom_addr_out,
  output logic            blink_out,
  output logic            run_out,
  output logic      [1:0] scan_digit_out,
  output logic      [2:0] scan_col_out,
  output logic      [6:0] scan_rows_out
);

  lmg_link_s  ql;
  lmg_link_s  dl;
  lmg_sys_s   q;
  lmg_sys_s   d;
  lmg_frame_s fr;
  logic [6:0] ram_host_rdata;
  logic [6:0] ram_scan_rdata;
  logic       frame_end;
  logic [6:0] addr;
  logic [7:0] code;
  logic [6:0] src;

  function automatic logic glyph_is_user(input logic [6:0] gc);
    return int'(gc) < USER_GLYPHS;
  endfunction : glyph_is_user

  function automatic logic [6:0] glyph_index(input logic [6:0] gc, input logic [2:0] c);
    return 7'(int'(gc) * ENTRIES_PER_GLYPH + int'(c));
  endfunction : glyph_index

  function automatic logic [7:0] ptr_after(input logic [7:0] p);
    return (p == PTR_LAST) ? PTR_FIRST : 8'(p + 8'h01);
  endfunction : ptr_after

  // link domain: sclk only runs inside frames, frames are exactly 16 clocks
  always_comb begin
    dl = ql;
    if (!cs_n_in) begin
      dl.shift   = {ql.shift[FRAME_BITS-2:0], din_in};
      dl.bit_cnt = 4'(ql.bit_cnt + 4'h1);
      // previous frame's answer is quasi-static here: the host leaves cs high long enough
      dl.tx      = (ql.bit_cnt == 4'h0) ? q.rd_word : {ql.tx[FRAME_BITS-2:0], 1'b0};
    end
  end

  always_ff @(posedge sclk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      ql <= '0;
    end else begin
      ql <= dl;
    end
  end

  lmg_glyph_mem #(
    .WIDTH (GLYPH_WIDTH),
    .DEPTH (GLYPH_ENTRIES),
    .AW    (7)
  ) u_glyph_mem (
    .clk_sys_in  (clk_sys_in),
    .nrst_in     (nrst_in),
    .we_in       (q.wr_en),
    .waddr_in    (q.wr_idx),
    .wdata_in    (q.wr_data),
    .raddr_a_in  (q.ptr[6:0]),
    .rdata_a_out (ram_host_rdata),
    .raddr_b_in  (q.scan_idx),
    .rdata_b_out (ram_scan_rdata)
  );

  always_comb begin
    d          = q;
    d.cs_meta  = cs_n_in;
    d.cs_sync  = q.cs_meta;
    d.cs_last  = q.cs_sync;
    d.wr_en    = 1'b0;
    frame_end  = q.cs_sync && !q.cs_last;
    fr         = ql.shift;  // stable: sclk is idle once cs has risen
    addr       = fr.cmd[6:0];
    code       = 8'h00;
    src        = 7'h00;

    // blink phase timer; cfg_slow holds the written rate bit, and 0 selects the slow rate
    if (q.blink_cnt >= BLINK_CNT_W'((!q.cfg_slow ? BLINK_HALF_CYC : BLINK_HALF_CYC / 2) - 1))
    begin
      d.blink_cnt = '0;
      d.phase_a   = !q.phase_a;
    end else begin
      d.blink_cnt = BLINK_CNT_W'(q.blink_cnt + 1);
    end

    // scan sequence: two lookups per column, then dwell
    unique case (q.scan)
      SC_ISSUE_A: begin
        code        = q.plane_a[q.digit];
        d.look_user = glyph_is_user(code[6:0]);
        d.scan_idx  = glyph_index(code[6:0], q.col);
        d.rom_addr  = {code[6:0], q.col};
        d.inv_a     = code[7];
        d.scan      = SC_ISSUE_B;
      end
      SC_ISSUE_B: begin
        code        = q.plane_b[q.digit];
        d.user_a    = q.look_user;
        d.look_user = glyph_is_user(code[6:0]);
        d.scan_idx  = glyph_index(code[6:0], q.col);
        d.rom_addr  = {code[6:0], q.col};
        d.inv_b     = code[7];
        d.scan      = SC_CATCH_A;
      end
      SC_CATCH_A: begin
        src     = q.user_a ? ram_scan_rdata : rom_col_in;
        d.pat_a = src ^ {7{q.inv_a}};
        d.scan  = SC_CATCH_B;
      end
      SC_CATCH_B: begin
        src = (q.look_user ? ram_scan_rdata : rom_col_in) ^ {7{q.inv_b}};
        if (!q.cfg_run) begin
          d.rows = 7'h00;
        end else if (q.cfg_blink_on && !q.phase_a) begin
          d.rows = src;
        end else begin
          d.rows = q.pat_a;
        end
        d.out_digit = q.digit;
        d.out_col   = q.col;
        d.dwell     = '0;
        d.scan      = SC_DWELL;
      end
      SC_DWELL: begin
        d.dwell = COL_CNT_W'(q.dwell + 1);
        if (q.dwell >= COL_CNT_W'(SCAN_COL_CYC - 5)) begin
          d.scan = SC_ISSUE_A;
          if (q.col == 3'(ENTRIES_PER_GLYPH - 1)) begin
            d.col   = 3'h0;
            d.digit = 2'(q.digit + 2'h1);
          end else begin
            d.col = 3'(q.col + 3'h1);
          end
        end
      end
    endcase

    // register port, acted on once per frame at the rising chip select
    if (frame_end) begin
      d.rd_word.cmd  = fr.cmd;
      d.rd_word.data = 8'h00;
      if (fr.cmd[CMD_READ_BIT]) begin
        if (addr == ADDR_CONFIG) begin
          d.rd_word.data[CFG_BLINK_STATE] = q.phase_a;
          d.rd_word.data[CFG_BLINK_ON]    = q.cfg_blink_on;
          d.rd_word.data[CFG_SLOW_RATE]   = q.cfg_slow;
          d.rd_word.data[CFG_RUN]         = q.cfg_run;
        end else if (addr == ADDR_GLYPH) begin
          d.rd_word.data = {1'b0, ram_host_rdata};
          d.ptr          = ptr_after(q.ptr);
        end else if (addr[6:2] == ADDR_PLANE_A[6:2]) begin
          d.rd_word.data = q.plane_a[addr[1:0]];
        end else if (addr[6:2] == ADDR_PLANE_B[6:2]) begin
          d.rd_word.data = q.plane_b[addr[1:0]];
        end
      end else begin
        if (addr == ADDR_CONFIG) begin
          d.cfg_run      = fr.data[CFG_RUN];
          d.cfg_slow     = fr.data[CFG_SLOW_RATE];
          d.cfg_blink_on = fr.data[CFG_BLINK_ON];
          if (fr.data[CFG_WIPE_CELLS]) begin
            d.plane_a = {DIGITS{WIPE_VALUE}};
            d.plane_b = {DIGITS{WIPE_VALUE}};
          end
          if (fr.data[CFG_BLINK_SYNC]) begin
            d.blink_cnt = '0;
            d.phase_a   = 1'b1;
            d.scan      = SC_ISSUE_A;
            d.digit     = 2'h0;
            d.col       = 3'h0;
            d.dwell     = '0;
          end
        end else if (addr == ADDR_GLYPH) begin
          if (fr.data[7]) begin
            d.ptr = (fr.data > PTR_LAST) ? PTR_FIRST : fr.data;
          end else begin
            d.wr_en   = 1'b1;
            d.wr_idx  = q.ptr[6:0];
            d.wr_data = fr.data[6:0];
            d.ptr     = ptr_after(q.ptr);
          end
        end else if (addr[6:2] == ADDR_PLANE_A[6:2]) begin
          d.plane_a[addr[1:0]] = fr.data;
        end else if (addr[6:2] == ADDR_PLANE_B[6:2]) begin
          d.plane_b[addr[1:0]] = fr.data;
        end else if (addr[6:2] == ADDR_PLANE_AB[6:2]) begin
          d.plane_a[addr[1:0]] = fr.data;
          d.plane_b[addr[1:0]] = fr.data;
        end
      end
    end
  end

  always_ff @(posedge clk_sys_in or negedge nrst_in) begin
    if (!nrst_in) begin
      q         <= '0;
      q.cs_meta <= 1'b1;
      q.cs_sync <= 1'b1;
      q.cs_last <= 1'b1;
      q.plane_a <= {DIGITS{DIGIT_RESET}};
      q.plane_b <= {DIGITS{DIGIT_RESET}};
      q.ptr     <= PTR_FIRST;
      q.phase_a <= 1'b1;
      q.scan    <= SC_ISSUE_A;
    end else begin
      q <= d;
    end
  end

  assign dout_out       = ql.tx[FRAME_BITS-1];
  assign rom_addr_out   = q.rom_addr;
  assign blink_out      = q.phase_a;
  assign run_out        = q.cfg_run;
  assign scan_digit_out = q.out_digit;
  assign scan_col_out   = q.out_col;
  assign scan_rows_out  = q.rows;

endmodule : lmg_display_ctrl

// ===== src/lmg_glyph_mem.sv
// glyph ram: one write port, two registered read ports
`timescale 1ns/10ps
module lmg_glyph_mem #(
  parameter int WIDTH = 7,
  parameter int DEPTH = 120,
  parameter int AW    = 7
) (
  input  wire logic             clk_sys_in,
  input  wire logic             nrst_in,
  input  wire logic             we_in,
  input  wire logic [AW-1:0]    waddr_in,
  input  wire logic [WIDTH-1:0] wdata_in,
  input  wire logic [AW-1:0]    raddr_a_in,
  output logic      [WIDTH-1:0] rdata_a_out,
  input  wire logic [AW-1:0]    raddr_b_in,
  output logic      [WIDTH-1:0] rdata_b_out
);

  // no reset on the array: contents are undefined until software writes them
  logic [WIDTH-1:0] mem [DEPTH];

  always_ff @(posedge clk_sys_in) begin
    if (we_in && (int'(waddr_in) < DEPTH)) begin
      mem[waddr_in] <= wdata_in;
    end
  end

  always_ff @(posedge clk_sys_in or negedge nrst_in) begin
    if (!nrst_in) begin
      rdata_a_out <= '0;
      rdata_b_out <= '0;
    end else begin
      rdata_a_out <= (int'(raddr_a_in) < DEPTH) ? mem[raddr_a_in] : '0;
      rdata_b_out <= (int'(raddr_b_in) < DEPTH) ? mem[raddr_b_in] : '0;
    end
  end

endmodule : lmg_glyph_mem

// ===== src/lmg_pkg.sv
// constants, carrier types and state layouts of the led matrix blink and glyph ram block
package lmg_pkg;

  localparam logic [6:0] ADDR_CONFIG   = 7'h04;
  localparam logic [6:0] ADDR_GLYPH    = 7'h05;
  localparam logic [6:0] ADDR_PLANE_A  = 7'h20;
  localparam logic [6:0] ADDR_PLANE_B  = 7'h40;
  localparam logic [6:0] ADDR_PLANE_AB = 7'h60;

  localparam int CMD_READ_BIT    = 7;
  localparam int CFG_RUN         = 0;
  localparam int CFG_SLOW_RATE   = 2;
  localparam int CFG_BLINK_ON    = 3;
  localparam int CFG_BLINK_SYNC  = 4;
  localparam int CFG_WIPE_CELLS  = 5;
  localparam int CFG_BLINK_STATE = 7;

  localparam logic [7:0] PTR_FIRST   = 8'h80;
  localparam logic [7:0] PTR_LAST    = 8'hF7;
  localparam logic [7:0] DIGIT_RESET = 8'h20;
  localparam logic [7:0] WIPE_VALUE  = 8'h00;

  localparam int DIGITS            = 4;
  localparam int GLYPH_ENTRIES     = 120;
  localparam int GLYPH_WIDTH       = 7;
  localparam int ENTRIES_PER_GLYPH = 5;
  localparam int USER_GLYPHS       = 24;
  localparam int FRAME_BITS        = 16;

  // blink timing is counted in multiplex clocks, so it scales with that clock
  localparam int REF_OSC_HZ          = 4_000_000;
  localparam int BLINK_SLOW_HALF_S   = 1;
  localparam int BLINK_SLOW_HALF_CYC = BLINK_SLOW_HALF_S * REF_OSC_HZ;
  localparam int BLINK_CNT_W         = 32;
  localparam int DIGIT_TIME_US       = 100;
  localparam int COL_CYC = DIGIT_TIME_US * (REF_OSC_HZ / 1_000_000) / ENTRIES_PER_GLYPH;
  localparam int COL_CNT_W           = 8;

  typedef struct packed {
    logic [7:0] cmd;
    logic [7:0] data;
  } lmg_frame_s;

  typedef enum logic [2:0] {
    SC_ISSUE_A = 3'b000,
    SC_ISSUE_B = 3'b001,
    SC_CATCH_A = 3'b011,
    SC_CATCH_B = 3'b010,
    SC_DWELL   = 3'b110
  } lmg_scan_e;

  typedef struct packed {
    logic [FRAME_BITS-1:0] shift;
    logic [3:0]            bit_cnt;
    logic [FRAME_BITS-1:0] tx;
  } lmg_link_s;

  typedef struct packed {
    logic                   cs_meta;
    logic                   cs_sync;
    logic                   cs_last;
    logic                   cfg_run;
    logic                   cfg_slow;
    logic                   cfg_blink_on;
    logic [DIGITS-1:0][7:0] plane_a;
    logic [DIGITS-1:0][7:0] plane_b;
    logic [7:0]             ptr;
    lmg_frame_s             rd_word;
    logic                   wr_en;
    logic [6:0]             wr_idx;
    logic [6:0]             wr_data;
    logic [BLINK_CNT_W-1:0] blink_cnt;
    logic                   phase_a;
    lmg_scan_e              scan;
    logic [1:0]             digit;
    logic [2:0]             col;
    logic [COL_CNT_W-1:0]   dwell;
    logic                   look_user;
    logic                   user_a;
    logic                   inv_a;
    logic                   inv_b;
    logic [6:0]             scan_idx;
    logic [9:0]             rom_addr;
    logic [6:0]             pat_a;
    logic [6:0]             rows;
    logic [1:0]             out_digit;
    logic [2:0]             out_col;
  } lmg_sys_s;

endpackage : lmg_pkg

// ===== verification/lmg_display_ctrl_asserts.sv
// port checker for the display controller, bound at the foot of this file
`timescale 1ns/10ps
module lmg_chk
  import lmg_pkg::*;
#(
  parameter int BLINK_HALF_CYC = 40,
  parameter int SCAN_COL_CYC   = 80
) (
  input wire logic       clk_sys_in,
  input wire logic       nrst_in,
  input wire logic       sclk_in,
  input wire logic       cs_n_in,
  input wire logic       din_in,
  input wire logic       dout_out,
  input wire logic       blink_out,
  input wire logic       run_out,
  input wire logic [1:0] scan_digit_out,
  input wire logic [2:0] scan_col_out
);
  logic [15:0] w_q;
  logic [15:0] f_q;
  logic [3:0]  n_q;
  logic [2:0]  c_q;
  logic        cfg_wr;
  always_ff @(posedge sclk_in) begin
    if (!cs_n_in) begin
      w_q <= {w_q[14:0], din_in};
    end
  end
  always_ff @(posedge sclk_in or posedge cs_n_in) begin
    if (cs_n_in) begin
      n_q <= 4'h0;
    end else begin
      n_q <= n_q + 4'h1;
    end
  end
  // the frame word is only read once chip select has been high for two clocks
  always_ff @(posedge clk_sys_in or negedge nrst_in) begin
    if (!nrst_in) begin
      c_q <= 3'h7;
      f_q <= 16'h0000;
    end else begin
      c_q <= {c_q[1:0], cs_n_in};
      if (c_q[1] && !c_q[2]) begin
        f_q <= w_q;
      end
    end
  end
  assign cfg_wr = c_q[1] && !c_q[2] && (w_q[15:8] == {1'b0, ADDR_CONFIG});

  sync_blink_a: assert property (@(posedge clk_sys_in) disable iff (!nrst_in)
    cfg_wr && w_q[CFG_BLINK_SYNC] |-> ##10 blink_out [*8]) else $error("blink not restarted");
  scan_restart_a: assert property (@(posedge clk_sys_in) disable iff (!nrst_in)
    cfg_wr && w_q[CFG_BLINK_SYNC] |-> ##[1:10] (scan_digit_out == 2'h0 && scan_col_out == 3'h0))
    else $error("scan not restarted");
  run_apply_a: assert property (@(posedge clk_sys_in) disable iff (!nrst_in)
    cfg_wr |-> ##[1:6] run_out == f_q[CFG_RUN]) else $error("run bit not applied");
  run_hold_a: assert property (@(posedge clk_sys_in) disable iff (!nrst_in)
    !c_q[2] |-> $stable(run_out)) else $error("run bit changed inside a frame");
  col_range_a: assert property (@(posedge clk_sys_in) disable iff (!nrst_in)
    scan_col_out <= 3'h4) else $error("column beyond five");
  digit_step_a: assert property (@(posedge clk_sys_in) disable iff (!nrst_in)
    $changed(scan_digit_out) |-> scan_col_out == 3'h0) else $error("digit step mid glyph");
  rd_msb_a: assert property (@(posedge sclk_in) disable iff (!nrst_in)
    n_q == 4'h9 && f_q[15:8] == 8'h85 |-> !dout_out) else $error("glyph read msb set");
  echo_cmd_a: assert property (@(posedge sclk_in) disable iff (!nrst_in)
    n_q == 4'h1 |-> dout_out == f_q[15]) else $error("answer does not lead with command");

  cover property (@(posedge clk_sys_in) cfg_wr && w_q[CFG_WIPE_CELLS]);
  cover property (@(posedge clk_sys_in) cfg_wr && w_q[CFG_BLINK_SYNC]);
  cover property (@(posedge sclk_in) n_q == 4'h9 && f_q[15:8] == 8'h85);
endmodule : lmg_chk

bind lmg_display_ctrl lmg_chk #(
  .BLINK_HALF_CYC(BLINK_HALF_CYC),
  .SCAN_COL_CYC  (SCAN_COL_CYC)
) i_lmg_chk (
  .clk_sys_in(clk_sys_in), .nrst_in(nrst_in), .sclk_in(sclk_in), .cs_n_in(cs_n_in),
  .din_in(din_in), .dout_out(dout_out), .blink_out(blink_out), .run_out(run_out),
  .scan_digit_out(scan_digit_out), .scan_col_out(scan_col_out)
);

// ===== verification/lmg_host_model.sv
// host side of the serial port; its link clock runs only inside frames
`timescale 1ns/10ps
module lmg_host_model (
  output logic      sclk_out,
  output logic      cs_n_out,
  output logic      din_out,
  input  wire logic dout_in
);
  initial begin
    sclk_out = 1'b0;
    cs_n_out = 1'b1;
    din_out  = 1'b1;
  end
  // msb first; the answer to the previous frame is taken on falling edges
  task automatic xfer(input logic [15:0] wr, output logic [15:0] rd);
    #1 cs_n_out = 1'b0;
    for (int i = 15; i >= 0; i--) begin
      din_out = wr[i];
      #15 sclk_out = 1'b1;
      #15 sclk_out = 1'b0;
      rd[i] = dout_in;
    end
    #15 cs_n_out = 1'b1;
    // a released line must not look like a held bit
    din_out = ~din_out;
    #60;
  endtask : xfer
endmodule : lmg_host_model

// ===== verification/tb_top.sv
// testbench: register traffic, glyph ram access, blink timing and scan rows
`timescale 1ns/10ps
module tb_top
  import lmg_pkg::*;
;
  localparam int BH = 500;
  logic       clk_sys, nrst, sclk, cs_n, din, dout, blink, run;
  logic [6:0] rows;
  logic [6:0] rom_col = 7'h00;
  logic [9:0] rom_addr;
  logic [1:0] digit;
  logic [2:0] col;
  int         err_count, tests_run, n;

  lmg_display_ctrl #(.BLINK_HALF_CYC(BH), .SCAN_COL_CYC(20)) i_lmg_display_ctrl (
    .clk_sys_in(clk_sys), .nrst_in(nrst), .sclk_in(sclk), .cs_n_in(cs_n), .din_in(din),
    .dout_out(dout), .rom_col_in(rom_col), .rom_addr_out(rom_addr), .blink_out(blink),
    .run_out(run), .scan_digit_out(digit), .scan_col_out(col), .scan_rows_out(rows)
  );
  lmg_host_model i_lmg_host_model (.sclk_out(sclk), .cs_n_out(cs_n), .din_out(din),
    .dout_in(dout));

  initial begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end
  // stand-in font rom, registered one clock behind its address
  always @(posedge clk_sys) rom_col <= rom_addr[9:3] ^ {4'h0, rom_addr[2:0]};

  function automatic logic [6:0] rom_gl(input logic [7:0] code);
    return code[6:0] ^ 7'h02 ^ {7{code[7]}};
  endfunction : rom_gl

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      err_count++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [15:0] r;
    i_lmg_host_model.xfer({a, d}, r);
  endtask : wr
  // the answer arrives during the next frame, so a no-op frame follows
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    logic [15:0] r;
    i_lmg_host_model.xfer({a, 8'h00}, r);
    i_lmg_host_model.xfer(16'h0000, r);
    check(r, {a, exp});
  endtask : rd_chk
  // column 2 of digit 0, compared against the plane of the current blink phase
  task automatic rows_chk(input logic [6:0] ea, input logic [6:0] eb);
    for (n = 0; n < 99 && digit === 2'h0 && col === 3'h2; n++) @(posedge clk_sys);
    for (n = 0; n < 2000 && !(digit === 2'h0 && col === 3'h2); n++) @(posedge clk_sys);
    repeat (3) @(posedge clk_sys);
    check(rows, blink ? ea : eb);
  endtask : rows_chk
  task automatic blink_len(input int lo, input int hi);
    for (n = 0; n < 3000 && blink !== 1'b0; n++) @(posedge clk_sys);
    check(n >= lo && n <= hi, 1'b1);
  endtask : blink_len
  task automatic end_sim();
    $display("checks %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : end_sim

  // limit is about eight times the expected run
  initial begin
    #300000;
    err_count++;
    end_sim();
  end

  initial begin
    nrst = 1'b0;
    err_count = 0;
    tests_run = 0;
    repeat (2) @(posedge clk_sys);
    check({run, blink}, 2'b01);
    nrst <= 1'b1;
    rd_chk(8'h84, 8'h80);
    rd_chk(8'hA0, DIGIT_RESET);
    $display("test reset done");
    wr(8'h05, 8'hF3);
    for (int i = 0; i < 5; i++) wr(8'h05, 8'h5A ^ 8'(i));
    wr(8'h05, 8'h2B);
    wr(8'h05, 8'h7F);
    wr(8'h05, 8'hF9);
    rd_chk(8'h85, 8'h2B);
    rd_chk(8'h85, 8'h7F);
    wr(8'h05, 8'hF3);
    for (int i = 0; i < 5; i++) rd_chk(8'h85, 8'h5A ^ 8'(i));
    rd_chk(8'h85, 8'h2B);
    $display("test glyph ram done");
    wr(8'h04, 8'h01);
    wr(8'h20, 8'h17);
    rows_chk(7'h58, 7'h58);
    wr(8'h20, 8'h97);
    rows_chk(7'h27, 7'h27);
    wr(8'h20, 8'h18);
    wr(8'h40, 8'h33);
    rows_chk(rom_gl(8'h18), rom_gl(8'h18));
    $display("test scan rows done");
    wr(8'h04, 8'h19);
    rd_chk(8'h84, 8'h89);
    for (int k = 0; k < 3; k++) rows_chk(rom_gl(8'h18), rom_gl(8'h33));
    wr(8'h04, 8'h19);
    blink_len(BH - 25, BH - 8);
    wr(8'h04, 8'h1D);
    blink_len(BH / 2 - 25, BH / 2 - 8);
    $display("test blink done");
    rd_chk(8'hC0, 8'h33);
    wr(8'h04, 8'h23);
    rd_chk(8'hA0, WIPE_VALUE);
    rd_chk(8'hC0, WIPE_VALUE);
    check(run, 1'b1);
    $display("test wipe done");
    end_sim();
  end
endmodule : tb_top
